// ---- rtl/ber_pkg.sv ----
// Constants for the per-lane PRBS bit-error-rate checker
package ber_pkg;
  localparam int LANES = 8;
  localparam int LANE_W = 32;
  localparam int CNT_W = 24;
  localparam logic [11:0] OFS_CLK_EN = 12'h315;
  localparam logic [11:0] OFS_CTRL = 12'h316;
  localparam logic [11:0] OFS_THR_LO = 12'h317;
  localparam logic [11:0] OFS_THR_MI = 12'h318;
  localparam logic [11:0] OFS_THR_HI = 12'h319;
  localparam logic [11:0] OFS_CNT_LO = 12'h31A;
  localparam logic [11:0] OFS_CNT_MI = 12'h31B;
  localparam logic [11:0] OFS_CNT_HI = 12'h31C;
  localparam logic [11:0] OFS_PASS = 12'h31D;
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_PAT_LSB = 2;
  localparam int CTRL_SEL_LSB = 4;
  localparam logic [1:0] PAT_PRBS7 = 2'h0;
  localparam logic [1:0] PAT_PRBS15 = 2'h1;
  localparam logic [7:0] CTRL_RW_MASK = 8'h7F;
  localparam logic [7:0] PASS_RESET = 8'hFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// ---- rtl/ber_lane_checker.sv ----
// One lane: self-synchronising PRBS error detector and saturating error counter
module ber_lane_checker
  import ber_pkg::*;
#(
  parameter int W = LANE_W,
  parameter int CW = CNT_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic [1:0] pattern_in,
  input wire logic [W-1:0] data_in,
  input wire logic valid_in,
  input wire logic [CW-1:0] threshold_in,
  output logic [CW-1:0] count_out,
  output logic pass_out
);
  typedef struct packed {
    logic [14:0] hist;
    logic [CW-1:0] cnt;
    logic pass;
  } lane_state_t;
  lane_state_t s_q, s_d;

  // Predicts each bit from the previous received bits, so no seed alignment is needed
  function automatic logic [5:0] popcount(input logic [W-1:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < W; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction

  always_comb begin
    logic [14:0] h;
    logic [W-1:0] err;
    logic exp;
    logic [CW:0] sum;
    h = s_q.hist;
    err = '0;
    exp = 1'b0;
    sum = '0;
    s_d = s_q;
    if (clear_in) begin
      s_d.hist = '0;
      s_d.cnt = '0;
      s_d.pass = 1'b1;
    end else if (enable_in && run_in && valid_in) begin
      for (int i = 0; i < W; i++) begin
        if (pattern_in == PAT_PRBS15) begin
          exp = h[14] ^ h[13];
        end else begin
          exp = h[6] ^ h[5];
        end
        err[i] = exp ^ data_in[i];
        h = {h[13:0], data_in[i]};
      end
      s_d.hist = h;
      sum = {1'b0, s_q.cnt} + {{(CW-5){1'b0}}, popcount(err)};
      // Saturates instead of wrapping so a long run never reports a falsely low count
      s_d.cnt = sum[CW] ? '1 : sum[CW-1:0];
      s_d.pass = s_q.pass && (s_d.cnt <= threshold_in);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '{hist: '0, cnt: '0, pass: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign count_out = s_q.cnt;
  assign pass_out = s_q.pass;
endmodule

// ---- rtl/ber_checker.sv ----
// Multi-lane PRBS bit-error-rate checker with byte-wide register port
module ber_checker
  import ber_pkg::*;
#(
  parameter int NL = LANES,
  parameter int W = LANE_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [NL*W-1:0] lane_data_in,
  input wire logic [NL-1:0] lane_valid_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out
);
  // One-hot, though the run_in and clear_in lane lines compare the whole state against ST_RUN or ST_CLEAR
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CLEAR = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HOLD = 4'b1000
  } test_state_t;

  typedef struct packed {
    logic clk_en;
    logic ctrl;
    logic [2:0] thr;
    logic [2:0] cnt;
    logic pass;
  } reg_hit_t;

  typedef struct packed {
    logic [7:0] clk_en;
    logic [7:0] ctrl;
    logic [CNT_W-1:0] thr;
    logic [7:0] rdata;
    logic rvalid;
    test_state_t st;
  } top_state_t;
  top_state_t s_q, s_d;

  logic [CNT_W-1:0] cnt [NL];
  logic [NL-1:0] pass;
  logic [7:0] pass_byte;
  logic [CNT_W-1:0] sel_cnt;
  logic [2:0] sel;

  assign sel = s_q.ctrl[CTRL_SEL_LSB +: 3];
  assign sel_cnt = (32'(sel) < NL) ? cnt[sel] : '0;

  always_comb begin
    pass_byte = PASS_RESET;
    for (int i = 0; i < NL && i < 8; i++) begin
      pass_byte[i] = pass[i];
    end
  end

  for (genvar g = 0; g < NL; g++) begin : g_lane
    ber_lane_checker #(.W(W), .CW(CNT_W)) u_lane (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .enable_in(s_q.clk_en[0]),
      .run_in(s_q.st == ST_RUN),
      .clear_in(s_q.st == ST_CLEAR),
      .pattern_in(s_q.ctrl[CTRL_PAT_LSB +: 2]),
      .data_in(lane_data_in[g*W +: W]),
      .valid_in(lane_valid_in[g]),
      .threshold_in(s_q.thr),
      .count_out(cnt[g]),
      .pass_out(pass[g])
    );
  end

  // Shared by the write and read paths so both always agree on the map
  function automatic reg_hit_t reg_decode(input logic [11:0] addr);
    reg_hit_t h;
    h = '0;
    case (addr)
      OFS_CLK_EN: h.clk_en = 1'b1;
      OFS_CTRL: h.ctrl = 1'b1;
      OFS_THR_LO: h.thr[0] = 1'b1;
      OFS_THR_MI: h.thr[1] = 1'b1;
      OFS_THR_HI: h.thr[2] = 1'b1;
      OFS_CNT_LO: h.cnt[0] = 1'b1;
      OFS_CNT_MI: h.cnt[1] = 1'b1;
      OFS_CNT_HI: h.cnt[2] = 1'b1;
      OFS_PASS: h.pass = 1'b1;
      default: h = '0;
    endcase
    return h;
  endfunction

  function automatic logic [7:0] byte_of(input logic [CNT_W-1:0] v, input logic [2:0] which);
    logic [7:0] b;
    b = BYTE_RESET;
    for (int i = 0; i < 3; i++) begin
      if (which[i]) begin
        b = v[i*8 +: 8];
      end
    end
    return b;
  endfunction

  function automatic logic [CNT_W-1:0] byte_into(input logic [CNT_W-1:0] v,
      input logic [2:0] which, input logic [7:0] b);
    logic [CNT_W-1:0] r;
    r = v;
    for (int i = 0; i < 3; i++) begin
      if (which[i]) begin
        r[i*8 +: 8] = b;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] read_byte(input reg_hit_t hit, input logic [7:0] clk_en,
      input logic [7:0] ctrl, input logic [CNT_W-1:0] thr, input logic [CNT_W-1:0] cnt_sel,
      input logic [7:0] pass_bits);
    logic [7:0] b;
    b = BYTE_RESET;
    if (hit.clk_en) begin
      b = clk_en;
    end
    if (hit.ctrl) begin
      b = ctrl;
    end
    if (|hit.thr) begin
      b = byte_of(thr, hit.thr);
    end
    if (|hit.cnt) begin
      b = byte_of(cnt_sel, hit.cnt);
    end
    if (hit.pass) begin
      b = pass_bits;
    end
    return b;
  endfunction

  // Clear outranks run, so a control byte with both bits set still empties the counters
  function automatic test_state_t next_test_state(input test_state_t cur,
      input logic [7:0] ctrl);
    test_state_t n;
    n = cur;
    case (cur)
      ST_IDLE: begin
        if (ctrl[CTRL_CLEAR_BIT]) begin
          n = ST_CLEAR;
        end else if (ctrl[CTRL_RUN_BIT]) begin
          n = ST_RUN;
        end
      end
      ST_CLEAR: begin
        if (!ctrl[CTRL_CLEAR_BIT]) begin
          n = ctrl[CTRL_RUN_BIT] ? ST_RUN : ST_IDLE;
        end
      end
      ST_RUN: begin
        if (ctrl[CTRL_CLEAR_BIT]) begin
          n = ST_CLEAR;
        end else if (!ctrl[CTRL_RUN_BIT]) begin
          n = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (ctrl[CTRL_CLEAR_BIT]) begin
          n = ST_CLEAR;
        end else if (ctrl[CTRL_RUN_BIT]) begin
          n = ST_RUN;
        end
      end
      default: begin
        n = ST_IDLE;
      end
    endcase
    return n;
  endfunction

  always_comb begin
    reg_hit_t rh;
    rh = reg_decode(reg_addr_in);
    s_d = s_q;
    s_d.rvalid = reg_read_in;
    if (reg_write_in) begin
      if (rh.clk_en) begin
        s_d.clk_en = reg_wdata_in;
      end
      // Clear is level-held while one so software sees counters stay cleared
      if (rh.ctrl) begin
        s_d.ctrl = reg_wdata_in & CTRL_RW_MASK;
      end
      s_d.thr = byte_into(s_q.thr, rh.thr, reg_wdata_in);
    end
    // Stepped from the new control byte, so the lanes see it at the same edge as before
    s_d.st = next_test_state(s_q.st, s_d.ctrl);
    if (reg_read_in) begin
      s_d.rdata = read_byte(rh, s_q.clk_en, s_q.ctrl, s_q.thr, sel_cnt, pass_byte);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '{clk_en: BYTE_RESET, ctrl: BYTE_RESET, thr: '0, rdata: BYTE_RESET, rvalid: 1'b0,
        st: ST_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign reg_rvalid_out = s_q.rvalid;
endmodule

// ---- test/ber_checker_monitor.sv ----
// Register port assertions for the lane error checker
module ber_checker_mon
  import ber_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic reg_rvalid_out,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic w = reg_write_in, r = reg_read_in;
  wire logic [11:0] a = reg_addr_in;
  wire logic [7:0] d = reg_wdata_in, q = reg_rdata_out;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  AST_ANSWER: assert property (r |=> reg_rvalid_out) else $error("no answer");
  AST_QUIET: assert property (!r |=> !reg_rvalid_out) else $error("stray");
  AST_HOLD: assert property (!r |=> $stable(q)) else $error("moved");
  AST_GAP: assert property (r && a == 12'h314 |=> q == 8'h00) else $error("gap");
  AST_THR: assert property (w && a == OFS_THR_LO ##1 !w ##1 r && a == OFS_THR_LO
    |=> q == $past(d, 3)) else $error("threshold");
  AST_CTRL: assert property (w && a == OFS_CTRL ##1 !w ##1 r && a == OFS_CTRL
    |=> q == ($past(d, 3) & CTRL_RW_MASK)) else $error("control");
  AST_CLEAR: assert property (w && a == OFS_CTRL && d[0] ##1 !w ##1 r && a == OFS_CNT_LO
    |=> q == BYTE_RESET) else $error("clear");
  AST_PASS: assert property (w && a == OFS_CTRL && d[0] ##1 !w [*3]
    ##1 r && a == OFS_PASS |=> q == PASS_RESET) else $error("pass");
endmodule

// ---- test/ber_tx.sv ----
// Far-end lane transmitter, one PRBS7 or PRBS15 word per clock
module ber_tx (
  input wire logic clk_in,
  input wire logic p15_in,
  output logic [31:0] word_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] s7 = 7'h01;
  logic [14:0] s15 = 15'h0001;
  // Both generators run always, so a pattern switch never meets a locked-up state
  always @(posedge clk_in) for (int i = 0; i < 32; i++) begin
    s7 = {s7[5:0], s7[6] ^ s7[5]};
    s15 = {s15[13:0], s15[14] ^ s15[13]};
    word_out[i] <= p15_in ? s15[0] : s7[0];
  end
endmodule

// ---- test/test_ber_checker.sv ----
// Bench for the lane error checker
module test_ber_checker
  import ber_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 0, rst_in = 1, reg_write_in = 0, reg_read_in = 0, reg_rvalid_out, z = 1;
  logic p15 = 0;
  logic [11:0] reg_addr_in = '0;
  logic [7:0] reg_wdata_in = '0, lane_valid_in = 8'hFF, e = '0, reg_rdata_out, pm;
  logic [255:0] lane_data_in = '0, nxt;
  logic [31:0] w, x = 32'h19, t;
  logic [7:0] q[$];
  int failures = 0, checked = 0;
  ber_checker ber_checker_i (.clk_sys_in, .rst_in, .reg_addr_in, .reg_write_in, .reg_read_in,
    .reg_wdata_in, .lane_data_in, .lane_valid_in, .reg_rdata_out, .reg_rvalid_out);
  ber_tx ber_tx_i (.clk_in(clk_sys_in), .p15_in(p15), .word_out(w));
  always #12.5 clk_sys_in = ~clk_sys_in;
  // Zero data keeps the error count exact: each flipped bit costs three errors
  // Lags hit and z by one word; their updates are non-blocking so nothing races here
  always @(negedge clk_sys_in) begin
    for (int g = 0; g < 8; g++) nxt[g*32 +: 32] = (z ? 32'h0 : w) ^ 32'(e[g]);
    lane_data_in = nxt;
  end
  always @(negedge clk_sys_in) if (reg_rvalid_out === 1'b1) begin
    checked++;
    if (reg_rdata_out !== q[0]) begin
      failures++;
      $display("BAD %0t %h %h", $time, reg_rdata_out, q[0]);
    end
    void'(q.pop_front());
  end
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys_in) {reg_addr_in, reg_wdata_in, reg_write_in} = {a, d, 1'b1};
    @(negedge clk_sys_in) reg_write_in = 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys_in) {reg_addr_in, reg_read_in} = {a, 1'b1};
    q.push_back(d);
    @(negedge clk_sys_in) reg_read_in = 0;
  endtask
  task automatic hit(input logic [7:0] m);
    @(negedge clk_sys_in) e <= m;
    @(negedge clk_sys_in) e <= 0;
  endtask
  task automatic thr(input logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_THR_LO + 12'(i), v[i*8 +: 8]);
      rd(OFS_THR_LO + 12'(i), v[i*8 +: 8]);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in) rst_in = 0;
    for (int a = 'h314; a < 'h31D; a++) rd(12'(a), 8'h00);
    rd(OFS_PASS, PASS_RESET);
    t = xs();
    thr(t[23:0]);
    t = t[7:0] % 25;
    thr(t[23:0]);
    wr(OFS_CLK_EN, 8'h01);
    wr(OFS_CTRL, 8'h01);
    wr(OFS_CTRL, 8'h02);
    for (int k = 0; k < 8; k++) hit(8'hFF << k);
    for (int g = 0; g < 8; g++) begin
      pm[g] = 3 * g + 3 <= t;
      wr(OFS_CTRL, 8'(8'h82 | g << 4));
      rd(OFS_CTRL, 8'(8'h02 | g << 4));
      rd(OFS_CNT_LO, 8'(3 * g + 3));
    end
    rd(OFS_PASS, pm);
    wr(OFS_CTRL, 8'h70);
    hit(8'hFF);
    rd(OFS_CNT_LO, 8'h18);
    wr(OFS_CLK_EN, 8'h00);
    wr(OFS_CTRL, 8'h72);
    hit(8'hFF);
    rd(OFS_CNT_LO, 8'h18);
    wr(OFS_CLK_EN, 8'h01);
    lane_valid_in = 8'h00;
    hit(8'hFF);
    rd(OFS_CNT_LO, 8'h18);
    lane_valid_in = 8'hFF;
    wr(OFS_CTRL, 8'h71);
    rd(OFS_CNT_LO, 8'h00);
    rd(OFS_PASS, PASS_RESET);
    thr(24'h000064);
    z <= 0;
    for (int p = 0; p < 4; p++) begin
      p15 = p[0];
      wr(OFS_CTRL, 8'(p[1] << 2 | 1));
      wr(OFS_CTRL, 8'(p[1] << 2 | 2));
      repeat (20) @(negedge clk_sys_in);
      rd(OFS_PASS, p[0] == p[1] ? PASS_RESET : 8'h00);
    end
    stop_test();
  end
endmodule
bind ber_checker ber_checker_mon ber_checker_mon_i (.clk_sys_in, .rst_in, .reg_addr_in,
  .reg_write_in, .reg_read_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out);
